// >>> include/tpf_pkg.sv
// Shared constants and types for the triple-port FIFO port control block.
`default_nettype none
package tpf_pkg;
    // Register byte addresses on the APB side.
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_OFFSET1 = 8'h08;
    localparam logic [7:0] ADDR_OFFSET2 = 8'h0c;
    // Control register: bit 0 is the active-low loopback select.
    localparam int CTRL_LOOP_N_BIT = 0;
    localparam logic CTRL_LOOP_N_RESET = 1'b1;
    // Status register field positions.
    localparam int ST_IN_READY1 = 0;
    localparam int ST_IN_READY2 = 1;
    localparam int ST_OUT_READY1 = 2;
    localparam int ST_OUT_READY2 = 3;
    localparam int ST_MBOX1 = 4;
    localparam int ST_MBOX2 = 5;
    localparam int ST_FWFT1 = 6;
    localparam int ST_FWFT2 = 7;
    localparam int ST_PROG_DONE = 8;
    localparam int ST_MODE_LSB = 9;
    // Offset register layout: almost-full offset in the upper half.
    localparam int OFF_HI_LSB = 16;
    // Port widths and sizes.
    localparam int A_W = 36;
    localparam int B_W = 18;
    localparam int DEPTH_DEFAULT = 2048;
    localparam int OFFSET_W_DEFAULT = 11;
    localparam int OFFSET_COUNT = 4;
    localparam int PARITY_SKIP_BIT = 8;
    // Flag select codes {fs2, fs1, fs0} caught at master reset release.
    localparam logic [2:0] FS_SERIAL = 3'h2;
    localparam logic [2:0] FS_PARALLEL = 3'h4;
    localparam logic [2:0] FS_PARITY = 3'h0;
    localparam logic [2:0] FS_P64 = 3'h7;
    localparam logic [2:0] FS_P16 = 3'h6;
    localparam logic [2:0] FS_P8 = 3'h5;
    localparam logic [2:0] FS_P256 = 3'h3;
    localparam logic [2:0] FS_P1024 = 3'h1;
    localparam int PRESET_64 = 64;
    localparam int PRESET_16 = 16;
    localparam int PRESET_8 = 8;
    localparam int PRESET_256 = 256;
    localparam int PRESET_1024 = 1024;
    // Offset programming method.
    typedef enum logic [1:0] {
        TPF_PRESET,
        TPF_SERIAL,
        TPF_PARALLEL,
        TPF_PARALLEL_ISP
    } tpf_prog_mode_t;
endpackage : tpf_pkg
`default_nettype wire

// >>> hdl/tpf_port_ctrl.sv
// Port control, offset loading and two FIFOs of the triple-port buffer.
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module tpf_port_ctrl #(
    parameter int DEPTH = tpf_pkg::DEPTH_DEFAULT,
    parameter int OFFSET_W = tpf_pkg::OFFSET_W_DEFAULT
) (
    // Clock and reset.
    input wire logic SYS_CLK,
    input wire logic RST,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [tpf_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Master resets, flag selects and timing mode.
    input wire logic FIFO1_MASTER_RESET_N,
    input wire logic FIFO2_MASTER_RESET_N,
    input wire logic FLAG_SELECT_0_SERIAL_DATA,
    input wire logic FLAG_SELECT_1_SERIAL_ENABLE,
    input wire logic FLAG_SELECT_2,
    input wire logic FALL_THROUGH_MODE_N,
    // Port A.
    input wire logic PORT_A_SELECT_N,
    input wire logic PORT_A_WRITE_NOT_READ,
    input wire logic PORT_A_ENABLE,
    input wire logic PORT_A_MAILBOX_SELECT,
    input wire logic [tpf_pkg::A_W-1:0] PORT_A_DIN,
    output logic [tpf_pkg::A_W-1:0] PORT_A_DOUT,
    output logic PORT_A_OE,
    // Port B.
    input wire logic PORT_B_SELECT_N,
    input wire logic PORT_B_READ_ENABLE,
    input wire logic PORT_B_MAILBOX_SELECT,
    output logic [tpf_pkg::B_W-1:0] PORT_B_DOUT,
    output logic PORT_B_OE,
    // Port C.
    input wire logic PORT_C_WRITE_ENABLE,
    input wire logic PORT_C_MAILBOX_SELECT,
    input wire logic [tpf_pkg::B_W-1:0] PORT_C_DIN,
    // Flags.
    output logic FIFO1_FULL_OR_INPUT_READY,
    output logic FIFO2_FULL_OR_INPUT_READY,
    output logic FIFO1_EMPTY_OR_OUTPUT_READY,
    output logic FIFO2_EMPTY_OR_OUTPUT_READY,
    output logic MAILBOX1_FLAG,
    output logic MAILBOX2_FLAG
);
    localparam int AW = $clog2(DEPTH);
    localparam int SW = tpf_pkg::OFFSET_COUNT * OFFSET_W;
    localparam int CW = $clog2(SW + 1);

    // Refuse sizes the pointer and offset logic cannot serve.
    if (DEPTH != (1 << OFFSET_W) || OFFSET_W < 10 || OFFSET_W > 13) begin : g_bad_size
        $error("DEPTH must equal 2**OFFSET_W with OFFSET_W from 10 to 13");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Master resets, timing mode and programming mode capture.

    logic [1:0] mrs_n;
    logic [1:0] mrs_prev;
    logic [1:0] rel;
    logic [1:0] f_rst;
    logic [1:0] fall_through_mode;
    logic [2:0] fs;
    tpf_pkg::tpf_prog_mode_t mode;

    assign mrs_n = {FIFO2_MASTER_RESET_N, FIFO1_MASTER_RESET_N};
    assign rel = mrs_n & ~mrs_prev;
    assign f_rst = {2{RST}} | ~mrs_n;
    assign fs = {FLAG_SELECT_2, FLAG_SELECT_1_SERIAL_ENABLE, FLAG_SELECT_0_SERIAL_DATA};

    // Previous master reset levels, used to find each release edge.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            mrs_prev <= 2'h0;
        end else begin
            mrs_prev <= mrs_n;
        end
    end

    // The timing mode is caught on the first edge after each release.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            fall_through_mode <= 2'h0;
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (rel[k]) begin
                    fall_through_mode[k] <= !FALL_THROUGH_MODE_N;
                end
            end
        end
    end

    // Maps a preset flag select code onto its offset value.
    function automatic logic [OFFSET_W-1:0] preset_value(input logic [2:0] code);
        case (code)
            tpf_pkg::FS_P16: return OFFSET_W'(tpf_pkg::PRESET_16);
            tpf_pkg::FS_P8: return OFFSET_W'(tpf_pkg::PRESET_8);
            tpf_pkg::FS_P256: return OFFSET_W'(tpf_pkg::PRESET_256);
            tpf_pkg::FS_P1024: return OFFSET_W'(tpf_pkg::PRESET_1024);
            default: return OFFSET_W'(tpf_pkg::PRESET_64);
        endcase
    endfunction : preset_value

    ////////////////////////////////////////////////////////////////////////////
    // Port decode.

    logic [1:0] in_ready;
    logic [1:0] out_ready;
    logic [1:0] wr_go;
    logic [1:0] rd_go;
    logic [tpf_pkg::A_W-1:0] wr_data [2];
    logic [tpf_pkg::A_W-1:0] out_word [2], head_word [2];
    logic ctrl_loop_n;
    logic prog_done;
    logic a_act, b_act, loop_on;
    logic a_fifo_wr, a_fifo_rd, a_mb_wr, a_mb_rd, lp_go;
    logic b_fifo_rd, b_mb_rd, c_mb_wr, par_load;

    // A port only acts with its enable high, so select changes alone do nothing.
    assign a_act = !PORT_A_SELECT_N && PORT_A_ENABLE;
    assign b_act = !PORT_B_SELECT_N && PORT_B_READ_ENABLE;
    assign loop_on = !ctrl_loop_n;
    assign a_fifo_wr = a_act && PORT_A_WRITE_NOT_READ && !PORT_A_MAILBOX_SELECT
        && !loop_on && in_ready[0];
    assign a_fifo_rd = a_act && !PORT_A_WRITE_NOT_READ && !PORT_A_MAILBOX_SELECT
        && !loop_on && out_ready[1];
    assign a_mb_wr = a_act && PORT_A_WRITE_NOT_READ && PORT_A_MAILBOX_SELECT && !loop_on;
    assign a_mb_rd = a_act && !PORT_A_WRITE_NOT_READ && PORT_A_MAILBOX_SELECT && !loop_on;
    // Loopback moves a word only while FIFO1 has room and FIFO2 has data.
    assign lp_go = a_act && !PORT_A_MAILBOX_SELECT && loop_on
        && in_ready[0] && out_ready[1];
    assign b_fifo_rd = b_act && !PORT_B_MAILBOX_SELECT && out_ready[0];
    assign b_mb_rd = b_act && PORT_B_MAILBOX_SELECT;
    assign c_mb_wr = PORT_C_WRITE_ENABLE && PORT_C_MAILBOX_SELECT;
    assign par_load = a_fifo_wr && !prog_done
        && (mode == tpf_pkg::TPF_PARALLEL || mode == tpf_pkg::TPF_PARALLEL_ISP);

    // FIFO write and read requests; the loop path feeds FIFO2's head word.
    assign wr_go[0] = (a_fifo_wr && !par_load) || lp_go;
    assign wr_data[0] = lp_go ? head_word[1] : PORT_A_DIN;
    assign wr_go[1] = PORT_C_WRITE_ENABLE && !PORT_C_MAILBOX_SELECT && in_ready[1];
    assign wr_data[1] = tpf_pkg::A_W'(PORT_C_DIN);
    assign rd_go[0] = b_fifo_rd;
    assign rd_go[1] = a_fifo_rd || lp_go;

    ////////////////////////////////////////////////////////////////////////////
    // Offset programming.

    logic [SW-1:0] offs;
    logic [CW-1:0] prog_cnt;
    logic [OFFSET_W-1:0] par_word;
    logic ser_shift;

    // Interspersed parity leaves bit eight out of the offset word.
    assign par_word = (mode == tpf_pkg::TPF_PARALLEL_ISP)
        ? {PORT_A_DIN[OFFSET_W:tpf_pkg::PARITY_SKIP_BIT+1],
           PORT_A_DIN[tpf_pkg::PARITY_SKIP_BIT-1:0]}
        : PORT_A_DIN[OFFSET_W-1:0];
    assign ser_shift = mode == tpf_pkg::TPF_SERIAL && !FLAG_SELECT_1_SERIAL_ENABLE
        && prog_cnt != CW'(SW) && !f_rst[0];

    // Mode capture, offset store and load progress.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            mode <= tpf_pkg::TPF_PRESET;
            offs <= {tpf_pkg::OFFSET_COUNT{OFFSET_W'(tpf_pkg::PRESET_64)}};
            prog_cnt <= '0;
            prog_done <= 1'b1;
        end else if (rel[0]) begin
            prog_cnt <= '0;
            prog_done <= 1'b0;
            case (fs)
                tpf_pkg::FS_SERIAL: mode <= tpf_pkg::TPF_SERIAL;
                tpf_pkg::FS_PARALLEL: mode <= tpf_pkg::TPF_PARALLEL;
                tpf_pkg::FS_PARITY: mode <= tpf_pkg::TPF_PARALLEL_ISP;
                default: begin
                    mode <= tpf_pkg::TPF_PRESET;
                    prog_done <= 1'b1;
                    offs[SW-1 -: 2*OFFSET_W] <= {2{preset_value(fs)}};
                    // A FIFO2 release on the same edge loads its presets too.
                    if (rel[1]) begin
                        offs[2*OFFSET_W-1:0] <= {2{preset_value(fs)}};
                    end
                end
            endcase
        end else begin
            if (rel[1] && mode == tpf_pkg::TPF_PRESET) begin
                offs[2*OFFSET_W-1:0] <= {2{preset_value(fs)}};
            end
            if (ser_shift) begin
                // The first almost-full MSB enters first and ends at the top.
                offs <= {offs[SW-2:0], FLAG_SELECT_0_SERIAL_DATA};
                prog_cnt <= prog_cnt + CW'(1);
            end else if (par_load) begin
                offs <= {offs[SW-OFFSET_W-1:0], par_word};
                prog_cnt <= prog_cnt + CW'(1);
            end
            // The ready flags rise on the edge after the last bit, FIFO2's alone after the last word.
            if ((mode == tpf_pkg::TPF_SERIAL && prog_cnt == CW'(SW))
                || (mode != tpf_pkg::TPF_SERIAL
                    && prog_cnt == CW'(tpf_pkg::OFFSET_COUNT))) begin
                prog_done <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The two FIFOs: memory, pointers, flag delay and output register.

    for (genvar i = 0; i < 2; i++) begin : g_fifo
        logic [tpf_pkg::A_W-1:0] mem [DEPTH];
        logic [AW-1:0] wp, rp;
        logic [AW:0] cnt;
        logic ne1, ne2, oval, avail, load;
        logic [tpf_pkg::A_W-1:0] oreg;
        logic prog_ok;

        // FIFO2 waits for any offset load; FIFO1 only for a serial one.
        assign prog_ok = prog_done || (i == 0 && mode != tpf_pkg::TPF_SERIAL);
        assign in_ready[i] = !f_rst[i] && prog_ok && cnt != (AW+1)'(DEPTH);
        // A written word is seen by the read side only two edges later.
        assign avail = ne2 && cnt != '0;
        assign out_ready[i] = fall_through_mode[i] ? oval : avail;
        assign load = avail && (fall_through_mode[i] ? (!oval || rd_go[i]) : rd_go[i]);
        assign out_word[i] = oreg;
        // The word a read moves out: the output register or the memory head.
        assign head_word[i] = fall_through_mode[i] ? oreg : mem[rp];

        // Memory write port.
        always_ff @(posedge SYS_CLK) begin
            if (wr_go[i]) begin
                mem[wp] <= wr_data[i];
            end
        end

        // Pointers, word count and the two-stage not-empty delay.
        always_ff @(posedge SYS_CLK) begin
            if (f_rst[i]) begin
                wp <= '0;
                rp <= '0;
                cnt <= '0;
                ne1 <= 1'b0;
                ne2 <= 1'b0;
            end else begin
                wp <= wp + AW'(wr_go[i]);
                rp <= rp + AW'(load);
                cnt <= cnt + (AW+1)'(wr_go[i]) - (AW+1)'(load);
                ne1 <= cnt != '0 && !(load && cnt == (AW+1)'(1));
                ne2 <= ne1 && !(load && cnt == (AW+1)'(1));
            end
        end

        // Output register; it holds its word whenever no load is taken.
        always_ff @(posedge SYS_CLK) begin
            if (f_rst[i]) begin
                oreg <= '0;
                oval <= 1'b0;
            end else if (load) begin
                oreg <= mem[rp];
                oval <= 1'b1;
            end else if (rd_go[i]) begin
                oval <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mailboxes and data outputs.

    logic [tpf_pkg::A_W-1:0] mbox1;
    logic [tpf_pkg::B_W-1:0] mbox2;
    logic a_show_mb, b_show_mb;

    // Mailbox storage; a write clears the flag and wins over a same-edge read.
    always_ff @(posedge SYS_CLK) begin
        if (f_rst[0]) begin
            mbox1 <= '0;
            MAILBOX1_FLAG <= 1'b1;
        end else if (a_mb_wr) begin
            mbox1 <= PORT_A_DIN;
            MAILBOX1_FLAG <= 1'b0;
        end else if (b_mb_rd) begin
            MAILBOX1_FLAG <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (f_rst[1]) begin
            mbox2 <= '0;
            MAILBOX2_FLAG <= 1'b1;
        end else if (c_mb_wr) begin
            mbox2 <= PORT_C_DIN;
            MAILBOX2_FLAG <= 1'b0;
        end else if (a_mb_rd) begin
            MAILBOX2_FLAG <= 1'b1;
        end
    end

    // Output source selection: the last read decides mailbox or FIFO word.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            a_show_mb <= 1'b0;
            b_show_mb <= 1'b0;
        end else begin
            if (a_mb_rd || a_fifo_rd || lp_go) begin
                a_show_mb <= a_mb_rd;
            end
            if (b_mb_rd || b_fifo_rd) begin
                b_show_mb <= b_mb_rd;
            end
        end
    end

    assign PORT_A_DOUT = a_show_mb ? tpf_pkg::A_W'(mbox2) : out_word[1];
    assign PORT_B_DOUT = b_show_mb ? mbox1[tpf_pkg::B_W-1:0] : out_word[0][tpf_pkg::B_W-1:0];
    assign PORT_A_OE = !PORT_A_SELECT_N && !PORT_A_WRITE_NOT_READ;
    assign PORT_B_OE = !PORT_B_SELECT_N;
    assign FIFO1_FULL_OR_INPUT_READY = in_ready[0];
    assign FIFO2_FULL_OR_INPUT_READY = in_ready[1];
    assign FIFO1_EMPTY_OR_OUTPUT_READY = out_ready[0];
    assign FIFO2_EMPTY_OR_OUTPUT_READY = out_ready[1];

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data captured in the setup cycle.

    logic [31:0] status;
    logic addr_ok;

    assign addr_ok = PADDR == tpf_pkg::ADDR_CTRL || PADDR == tpf_pkg::ADDR_STATUS
        || PADDR == tpf_pkg::ADDR_OFFSET1 || PADDR == tpf_pkg::ADDR_OFFSET2;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_ok;
    assign status = 32'({mode, prog_done, fall_through_mode, MAILBOX2_FLAG, MAILBOX1_FLAG,
        out_ready, in_ready});

    // Control register write.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ctrl_loop_n <= tpf_pkg::CTRL_LOOP_N_RESET;
        end else if (PSEL && PENABLE && PWRITE && PADDR == tpf_pkg::ADDR_CTRL) begin
            ctrl_loop_n <= PWDATA[tpf_pkg::CTRL_LOOP_N_BIT];
        end
    end

    // Read data register.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            PRDATA <= 32'h0;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            case (PADDR)
                tpf_pkg::ADDR_CTRL: PRDATA <= 32'(ctrl_loop_n);
                tpf_pkg::ADDR_STATUS: PRDATA <= status;
                tpf_pkg::ADDR_OFFSET1: PRDATA <= (32'(offs[SW-1 -: OFFSET_W])
                    << tpf_pkg::OFF_HI_LSB) | 32'(offs[SW-OFFSET_W-1 -: OFFSET_W]);
                tpf_pkg::ADDR_OFFSET2: PRDATA <= (32'(offs[2*OFFSET_W-1 -: OFFSET_W])
                    << tpf_pkg::OFF_HI_LSB) | 32'(offs[OFFSET_W-1:0]);
                default: PRDATA <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    sequence s_not_ready2;
        !out_ready[0] ##1 !out_ready[0];
    endsequence

    sequence s_not_ready3;
        !out_ready[0] ##1 !out_ready[0] ##1 !out_ready[0];
    endsequence

    port_a_hiz_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (PORT_A_SELECT_N || PORT_A_WRITE_NOT_READ) |-> !PORT_A_OE)
        else $error("port A drives while not selected for read");

    mbox2_read_a: assert property (@(posedge SYS_CLK) disable iff (f_rst[1])
        (a_mb_rd && !c_mb_wr) |=> MAILBOX2_FLAG && PORT_A_DOUT == tpf_pkg::A_W'(mbox2))
        else $error("mailbox 2 read did not return data with flag high");

    mbox1_read_a: assert property (@(posedge SYS_CLK) disable iff (f_rst[0])
        (b_mb_rd && !a_mb_wr) |=> MAILBOX1_FLAG && PORT_B_DOUT == mbox1[tpf_pkg::B_W-1:0])
        else $error("mailbox 1 read did not return data with flag high");

    port_b_drive_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (!PORT_B_SELECT_N && !PORT_B_READ_ENABLE) |-> PORT_B_OE)
        else $error("port B not driven while selected");

    serial_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (mode == tpf_pkg::TPF_SERIAL && !prog_done)
        |-> !FIFO1_FULL_OR_INPUT_READY && !FIFO2_FULL_OR_INPUT_READY)
        else $error("input ready raised during serial offset load");

    std_empty_a: assert property (@(posedge SYS_CLK) disable iff (f_rst[0])
        (!fall_through_mode[0] && g_fifo[0].cnt == '0 && !g_fifo[0].ne1 && wr_go[0])
        |=> s_not_ready2 ##1 out_ready[0])
        else $error("empty flag did not rise on second read edge");

    fall_through_mode_load_a: assert property (@(posedge SYS_CLK) disable iff (f_rst[0])
        (fall_through_mode[0] && !g_fifo[0].oval && g_fifo[0].cnt == '0 && !g_fifo[0].ne1 && wr_go[0])
        |=> s_not_ready3 ##1 (out_ready[0] && out_word[0] == $past(wr_data[0], 4)))
        else $error("fall-through word not loaded with output ready");

    full_ignore_a: assert property (@(posedge SYS_CLK) disable iff (f_rst[1])
        (!in_ready[1] && !rd_go[1]) |=> g_fifo[1].cnt == $past(g_fifo[1].cnt))
        else $error("write taken by a FIFO that is not ready");

    empty_hold_a: assert property (@(posedge SYS_CLK) disable iff (f_rst[0])
        (!out_ready[0] && !fall_through_mode[0]) |=> $stable(out_word[0]))
        else $error("output register changed while FIFO not ready");

    loop_move_a: assert property (@(posedge SYS_CLK) disable iff (f_rst[0] || f_rst[1])
        (lp_go && !b_fifo_rd && !g_fifo[0].load) |=> g_fifo[0].cnt == $past(g_fifo[0].cnt) + 1)
        else $error("loopback word not written into FIFO1");
endmodule : tpf_port_ctrl
`default_nettype wire

// >>> verif/tpf_serial_host.sv
// Host model that straps serial offset loading and shifts the offsets in.
`timescale 1ns/1ps
`default_nettype none
module tpf_serial_host #(
    parameter int OW = 11,
    // Offsets sent in order almost-full 1, almost-empty 1, almost-full 2, almost-empty 2.
    parameter logic [4*OW-1:0] OFFS = {11'h123, 11'h045, 11'h3f0, 11'h00a}
) (
    // Clock and start request.
    input wire logic clk,
    input wire logic go,
    // Strap and serial pins.
    output logic fifo1_master_reset_n,
    output logic fifo2_master_reset_n,
    output logic fs0,
    output logic fs1,
    output logic fsel2,
    output logic done
);
    ////////////////////////////////////////////////////////////////
    // Both resets release on one edge with serial straps, then one bit per edge.
    initial begin
        fifo1_master_reset_n = 1'b0;
        fifo2_master_reset_n = 1'b0;
        fsel2 = 1'b0;
        fs1 = 1'b1;
        fs0 = 1'b0;
        done = 1'b0;
        wait (go === 1'b1);
        @(posedge clk);
        fifo1_master_reset_n <= 1'b1;
        fifo2_master_reset_n <= 1'b1;
        @(posedge clk);
        for (int i = 4 * OW - 1; i >= 0; i--) begin
            fs1 <= 1'b0;
            fs0 <= OFFS[i];
            @(posedge clk);
        end
        fs1 <= 1'b1;
        fs0 <= ~OFFS[0];
        done <= 1'b1;
    end
endmodule : tpf_serial_host
`default_nettype wire

// >>> verif/tb_triple_port_fifo_port_control.sv
// Self-checking bench for the triple-port FIFO port control.
`timescale 1ns/1ps
`default_nettype none
module tb_triple_port_fifo_port_control;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0, slv;
    logic a_sel_n = 1'b1, a_w = 1'b0, a_en = 1'b0, a_mb = 1'b0, b_sel_n = 1'b1, b_ren = 1'b0;
    logic b_mb = 1'b0, c_we = 1'b0, c_mb = 1'b0, pready, pslverr, a_oe, b_oe, done;
    logic ir1, ir2, or1, or2, mb1, mb2, fifo1_master_reset_n, fifo2_master_reset_n, fs0, fs1, fsel2, fall_through_mode_n = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [35:0] a_din = 36'h0, a_dout;
    logic [17:0] c_din = 18'h0, b_dout;
    int err_total = 0, n_checks = 0, n;
    ////////////////////////////////////////////////////////////////
    // Clock at 50 MHz.
    always #10 clk = ~clk;
    tpf_port_ctrl uut (.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .FIFO1_MASTER_RESET_N(fifo1_master_reset_n), .FIFO2_MASTER_RESET_N(fifo2_master_reset_n),
        .FLAG_SELECT_0_SERIAL_DATA(fs0), .FLAG_SELECT_1_SERIAL_ENABLE(fs1),
        .FLAG_SELECT_2(fsel2), .FALL_THROUGH_MODE_N(fall_through_mode_n), .PORT_A_SELECT_N(a_sel_n),
        .PORT_A_WRITE_NOT_READ(a_w), .PORT_A_ENABLE(a_en), .PORT_A_MAILBOX_SELECT(a_mb),
        .PORT_A_DIN(a_din), .PORT_A_DOUT(a_dout), .PORT_A_OE(a_oe), .PORT_B_SELECT_N(b_sel_n),
        .PORT_B_READ_ENABLE(b_ren), .PORT_B_MAILBOX_SELECT(b_mb), .PORT_B_DOUT(b_dout),
        .PORT_B_OE(b_oe), .PORT_C_WRITE_ENABLE(c_we), .PORT_C_MAILBOX_SELECT(c_mb),
        .PORT_C_DIN(c_din), .FIFO1_FULL_OR_INPUT_READY(ir1), .FIFO2_FULL_OR_INPUT_READY(ir2),
        .FIFO1_EMPTY_OR_OUTPUT_READY(or1), .FIFO2_EMPTY_OR_OUTPUT_READY(or2),
        .MAILBOX1_FLAG(mb1), .MAILBOX2_FLAG(mb2));
    tpf_serial_host host (.clk(clk), .go(go), .fifo1_master_reset_n(fifo1_master_reset_n), .fifo2_master_reset_n(fifo2_master_reset_n), .fs0(fs0),
        .fs1(fs1), .fsel2(fsel2), .done(done));
    // Comparison, closing report and bus tasks.
    task chk(input string nm, input logic [35:0] got, input logic [35:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge clk); psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= ad; pwdata <= wd;
        @(posedge clk); pen <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 20) begin err_total++; end_of_test(); end
    endtask : apb
    task tick(input int k); repeat (k) @(posedge clk); #1; endtask : tick
    task pa(input logic w, input logic m, input logic [35:0] d);
        @(posedge clk); a_sel_n <= 1'b0; a_en <= 1'b1; a_w <= w; a_mb <= m; a_din <= d;
        @(posedge clk); a_en <= 1'b0; #1;
    endtask : pa
    task pb(input logic m);
        @(posedge clk); b_sel_n <= 1'b0; b_ren <= 1'b1; b_mb <= m;
        @(posedge clk); b_ren <= 1'b0; #1;
    endtask : pb
    task pc(input logic m, input logic [17:0] d);
        @(posedge clk); c_we <= 1'b1; c_mb <= m; c_din <= d;
        @(posedge clk); c_we <= 1'b0; #1;
    endtask : pc
    ////////////////////////////////////////////////////////////////
    // Main sequence: serial load, FIFO paths, mailboxes, loopback.
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        go <= 1'b1;
        n = 0;
        while (done !== 1'b1 && n < 200) begin @(posedge clk); #1; n++; end
        if (n >= 200) begin err_total++; end_of_test(); end
        chk("ready_in", {ir1, ir2}, 36'h0);
        tick(1);
        chk("ready_in", {ir1, ir2}, 36'h3);
        apb(1'b0, tpf_pkg::ADDR_OFFSET1, 32'h0);
        chk("offset1", rd, 36'h001230045);
        apb(1'b0, tpf_pkg::ADDR_OFFSET2, 32'h0);
        chk("offset2", rd, 36'h003f0000a);
        apb(1'b0, tpf_pkg::ADDR_STATUS, 32'h0);
        chk("mode", rd[10:8], 36'h3);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", {slv, rd}, 36'h100000000);
        $display("end of serial test");
        pc(1'b0, 18'h2b3c1);
        tick(1);
        chk("ready2", or2, 36'h0);
        tick(1);
        chk("ready2", or2, 36'h1);
        pa(1'b0, 1'b0, 36'h0);
        chk("a_read", {a_oe, or2, a_dout[33:0]}, {2'b10, 34'h2b3c1});
        pa(1'b0, 1'b0, 36'h0);
        chk("a_hold", a_dout, 36'h2b3c1);
        pa(1'b1, 1'b0, 36'h987654321);
        tick(2);
        chk("a_wr", {a_oe, b_oe, or1}, 36'h1);
        pb(1'b0);
        chk("b_read", {b_oe, b_dout}, 36'h54321);
        a_din <= 36'h111111111;
        tick(3);
        chk("idle_a", or1, 36'h0);
        $display("end of fifo test");
        pa(1'b1, 1'b1, 36'h5a5a5a5a5);
        chk("mbox1", mb1, 36'h0);
        pb(1'b1);
        chk("mbox1_rd", {mb1, b_dout}, 36'h5a5a5);
        pc(1'b1, 18'h3c3c3);
        chk("mbox2", mb2, 36'h0);
        pa(1'b0, 1'b1, 36'h0);
        chk("mbox2_rd", {mb2, a_dout[34:0]}, {1'b1, 35'h3c3c3});
        $display("end of mailbox test");
        apb(1'b1, tpf_pkg::ADDR_CTRL, 32'h0);
        for (int k = 0; k < 2; k++) begin
            pc(1'b0, 18'h1e1e1 ^ 18'(k));
            tick(2);
            pa(k == 0, 1'b0, 36'h0);
            if (k == 1) chk("loop_a", a_dout, 36'h1e1e0);
            tick(2);
            chk("loop_rdy", {or2, or1}, 36'h1);
            pb(1'b0);
            chk("loop_b", b_dout, 36'h1e1e1 ^ 36'(k));
        end
        pa(1'b0, 1'b0, 36'h0);
        tick(3);
        chk("loop_empty", or1, 36'h0);
        a_sel_n <= 1'b1;
        tick(1);
        chk("a_off", a_oe, 36'h0);
        $display("end of loopback test");
        // Mid-run reset with fall-through strapped: FIFO1 presents words unrequested.
        fall_through_mode_n <= 1'b0;
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(2);
        apb(1'b0, tpf_pkg::ADDR_STATUS, 32'h0);
        chk("fall_through_mode_mode", rd[10:6], 36'h7);
        pa(1'b1, 1'b0, 36'h12345);
        pa(1'b1, 1'b0, 36'h0abcd);
        tick(1);
        chk("fall_through_mode_first", {or1, b_dout}, 36'h52345);
        tick(2);
        chk("fall_through_mode_hold", b_dout, 36'h12345);
        pb(1'b0);
        chk("fall_through_mode_next", {or1, b_dout}, 36'h4abcd);
        $display("end of fall-through test");
        end_of_test();
    end
endmodule : tb_triple_port_fifo_port_control
`default_nettype wire
